/* hw/sdram_burst_consts.vh */
// Constants for the synchronous DRAM burst command logic
`ifndef SDRAM_BURST_CONSTS_VH
`define SDRAM_BURST_CONSTS_VH
`define REG_MODE 4'h0
`define REG_STATUS 4'h4
`define MODE_BL_LSB 0
`define MODE_BL_MSB 2
`define MODE_IL_BIT 3
`define MODE_CL3_BIT 4
`define MODE_RST 5'h13
`define BL_FULL 3'h7
`define CL_LOW 2'h2
`define CL_HIGH 2'h3
`define POST_STORE_GAP 2'h2
`define PRE_FLAG_BIT 10
`define CMD_ACT 3'h3
`define CMD_RD 3'h5
`define CMD_WR 3'h4
`define CMD_PRE 3'h2
`define CMD_BST 3'h6
`define CMD_SREF 3'h1
`define ST_BANK_LSB 0
`define ST_BURST 2
`define ST_WRITE 3
`define ST_AP 4
`define ST_SUSPEND 5
`define ST_PDOWN 6
`define ST_SREF 7
`endif

/* hw/sdram_burst_command_logic.v */
// Command decoder, burst engine and data path of a two-bank synchronous DRAM
// Behaviour
// - Read command starts burst at given column
// - Write command takes first word same cycle
// - Later words each edge; extras discarded
// - Read interrupts read; old data until latency
// - Write interrupts write, restarts from new column
// - Read ends write at once; leftovers ignored
// - Burst stop ends full-page burst, bank stays
// - After stop, read data ends after latency
// - Sequential order wraps in low bits only
// - Interleave order is start XOR beat
// - Address bit ten requests auto-precharge
// - Read auto-precharge starts latency-dependent clocks early
// - Write auto-precharge starts two clocks after
// - Precharge closes one bank or all
// - Self refresh entry; ignore inputs while held
// - Self refresh ends when clock gate rises
// - Clock gate low with no burst: power down
// - No-operation and deselect leave burst running
// - Clock gate low suspends a clock later
// - Byte mask: read two-cycle, write immediate
`timescale 1ns/1ps
`default_nettype none
`include "sdram_burst_consts.vh"

module sdram_burst_command_logic #(
  parameter COL_STORE_W = 4
) (
  input wire ref_clk, // System clock
  input wire rst_b, // Synchronous reset, active low
  input wire chip_select_n, // Command decoder enable
  input wire row_strobe_n, // Row strobe
  input wire column_strobe_n, // Column strobe
  input wire write_strobe_n, // Write strobe
  input wire clock_gate, // Clock enable pin
  input wire array_pick, // Bank select
  input wire [10:0] addr_pins, // Row or column address
  input wire [1:0] byte_mask, // Per-byte data mask
  input wire [15:0] dq_in, // Data pins, inward
  output reg [15:0] dq_out, // Data pins, outward
  output reg [1:0] dq_oe, // Per-byte drive enable
  input wire [3:0] avs_address, // Register byte address
  input wire avs_read, // Register read
  input wire avs_write, // Register write
  input wire [31:0] avs_writedata, // Register write data
  input wire [3:0] avs_byteenable, // Register byte lanes
  output reg [31:0] avs_readdata, // Register read data
  output reg avs_waitrequest // Register stall
);

  localparam STORE_DEPTH = 1 << (COL_STORE_W + 1);

  reg [4:0] mode_q;
  reg cke_q;
  reg sr_q;
  wire [1:0] bank_open;
  reg bst_act;
  reg bst_wr;
  reg bst_bank;
  reg bst_ap;
  reg bst_il;
  reg [2:0] bst_bl;
  reg [7:0] bst_start;
  reg [7:0] beat;
  reg ap_pend;
  reg [1:0] ap_cnt;
  reg ap_bank;
  reg pv0;
  reg pv1;
  reg [15:0] pipe0;
  reg [15:0] pipe1;
  reg [1:0] dm_q;

  wire [2:0] cmd;
  wire cmd_ok;
  wire new_rd;
  wire new_wr;
  wire new_b;
  wire stop_now;
  wire [7:0] cur_start;
  wire [7:0] cur_beat;
  wire [2:0] cur_bl;
  wire cur_il;
  wire cur_bank;
  wire cur_wr;
  wire cur_ap;
  wire cur_act;
  wire cur_full;
  wire [7:0] mask;
  wire [7:0] col;
  wire beat_last;
  wire beat_go;
  wire wr_en;
  wire rd_push;
  wire [1:0] cl;
  wire rd_ap_trig;
  wire wr_ap_done;
  wire [COL_STORE_W:0] idx;
  wire [15:0] mem_rd;
  wire [31:0] status;
  wire pd_now;
  wire susp_now;
  wire bus_req;
  wire bus_take;
  wire sr_entry;
  reg is_act;
  reg is_rd;
  reg is_wr;
  reg is_pre;
  reg is_bst;
  reg is_sref;

  function [7:0] len_mask;
    input [2:0] code;
    begin
      case (code)
        3'h0: len_mask = 8'h00;
        3'h1: len_mask = 8'h01;
        3'h2: len_mask = 8'h03;
        3'h3: len_mask = 8'h07;
        default: len_mask = 8'hff;
      endcase
    end
  endfunction

  // Command decode; commands count only when the clock gate was high last edge
  assign cmd = {row_strobe_n, column_strobe_n, write_strobe_n};

  // Strobe pattern decode; at most one flag is high
  always @*
  begin
    is_act = 1'b0;
    is_rd = 1'b0;
    is_wr = 1'b0;
    is_pre = 1'b0;
    is_bst = 1'b0;
    is_sref = 1'b0;
    case (cmd)
      `CMD_ACT: is_act = 1'b1;
      `CMD_RD: is_rd = 1'b1;
      `CMD_WR: is_wr = 1'b1;
      `CMD_PRE: is_pre = 1'b1;
      `CMD_BST: is_bst = 1'b1;
      `CMD_SREF: is_sref = 1'b1;
      default: is_act = 1'b0;
    endcase
  end

  assign cmd_ok = cke_q & ~chip_select_n & ~sr_q;
  assign new_rd = cmd_ok & is_rd & bank_open[array_pick];
  assign new_wr = cmd_ok & is_wr & bank_open[array_pick];
  assign new_b = new_rd | new_wr;
  assign stop_now = cmd_ok & (is_bst |
    (is_pre & (addr_pins[`PRE_FLAG_BIT] | (array_pick == bst_bank))));
  // Entry only with every bank idle
  assign sr_entry = cmd_ok & ~clock_gate & is_sref & ~|bank_open;

  // Burst context: a fresh command replaces the running burst
  assign cur_start = new_b ? addr_pins[7:0] : bst_start;
  assign cur_beat = new_b ? 8'h00 : beat;
  assign cur_bl = new_b ? mode_q[`MODE_BL_MSB:`MODE_BL_LSB] : bst_bl;
  assign cur_il = new_b ? mode_q[`MODE_IL_BIT] : bst_il;
  assign cur_bank = new_b ? array_pick : bst_bank;
  assign cur_wr = new_b ? new_wr : bst_wr;
  assign cur_full = (cur_bl == `BL_FULL);
  assign cur_ap = new_b ? (addr_pins[`PRE_FLAG_BIT] & ~cur_full) : bst_ap;
  assign cur_act = new_b | bst_act;
  assign mask = len_mask(cur_bl);

  // Column order: sequential adds within the mask, interleave flips bits
  assign col = (cur_start & ~mask) | (mask & ((cur_il & ~cur_full) ?
    (cur_start ^ cur_beat) : (cur_start + cur_beat)));
  assign beat_last = ~cur_full & (cur_beat == mask);
  assign beat_go = cke_q & cur_act & ~stop_now;
  assign wr_en = beat_go & cur_wr;
  assign rd_push = beat_go & ~cur_wr;
  assign cl = mode_q[`MODE_CL3_BIT] ? `CL_HIGH : `CL_LOW;

  // Read auto-precharge begins latency minus one clocks before the burst end
  assign rd_ap_trig = rd_push & cur_ap &
    (({1'b0, cur_beat} + {7'h00, cl}) >= ({1'b0, mask} + 9'h001));
  assign wr_ap_done = cke_q & ap_pend & (ap_cnt == 2'h0);

  assign idx = {cur_bank, col[COL_STORE_W-1:0]};

  // Storage, one array per byte lane so masked bytes keep their contents
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : lane
      reg [7:0] store [0:STORE_DEPTH-1];
      always @(posedge ref_clk)
      begin
        if (wr_en & ~byte_mask[g])
          store[idx] <= dq_in[g*8 +: 8];
      end
      assign mem_rd[g*8 +: 8] = store[idx];
    end
  endgenerate

  // Bank open state, one flag per bank
  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1)
    begin : bank
      reg open_q;
      wire act_b;
      wire close_b;
      assign act_b = cmd_ok & is_act & (array_pick == b);
      assign close_b = (cmd_ok & is_pre &
        (addr_pins[`PRE_FLAG_BIT] | (array_pick == b))) |
        (rd_ap_trig & (cur_bank == b)) | (wr_ap_done & (ap_bank == b));
      assign bank_open[b] = open_q;
      always @(posedge ref_clk)
      begin
        if (!rst_b)
          open_q <= 1'b0;
        else if (act_b)
          open_q <= 1'b1;
        else if (close_b)
          open_q <= 1'b0;
      end
    end
  endgenerate

  // Clock gate history and self refresh
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      cke_q <= 1'b1;
      sr_q <= 1'b0;
    end
    else
    begin
      cke_q <= clock_gate;
      if (sr_q & clock_gate)
        sr_q <= 1'b0;
      else if (sr_entry)
        sr_q <= 1'b1;
    end
  end

  // Burst engine
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      bst_act <= 1'b0;
      bst_wr <= 1'b0;
      bst_bank <= 1'b0;
      bst_ap <= 1'b0;
      bst_il <= 1'b0;
      bst_bl <= 3'h0;
      bst_start <= 8'h00;
      beat <= 8'h00;
    end
    else
    begin
      if (new_b)
      begin
        bst_start <= cur_start;
        bst_bl <= cur_bl;
        bst_il <= cur_il;
        bst_bank <= cur_bank;
        bst_wr <= cur_wr;
        bst_ap <= cur_ap;
      end
      if (beat_go)
      begin
        beat <= cur_beat + 8'h01;
        bst_act <= ~beat_last;
      end
      else if (stop_now)
        bst_act <= 1'b0;
    end
  end

  // Write auto-precharge delay after the last beat
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      ap_pend <= 1'b0;
      ap_cnt <= 2'h0;
      ap_bank <= 1'b0;
    end
    else if (wr_en & cur_ap & beat_last)
    begin
      ap_pend <= 1'b1;
      ap_cnt <= `POST_STORE_GAP - 2'h1;
      ap_bank <= cur_bank;
    end
    else if (cke_q & ap_pend)
    begin
      if (ap_cnt == 2'h0)
        ap_pend <= 1'b0;
      else
        ap_cnt <= ap_cnt - 2'h1;
    end
  end

  // Read pipeline; frozen during suspend so data resumes where it stopped
  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      pv0 <= 1'b0;
      pv1 <= 1'b0;
      pipe0 <= 16'h0000;
      pipe1 <= 16'h0000;
      dm_q <= 2'h0;
      dq_out <= 16'h0000;
      dq_oe <= 2'h0;
    end
    else if (cke_q)
    begin
      pv0 <= rd_push;
      pipe0 <= mem_rd;
      pv1 <= pv0;
      pipe1 <= pipe0;
      dm_q <= byte_mask;
      dq_out <= (cl == `CL_HIGH) ? pipe1 : pipe0;
      dq_oe <= {2{(cl == `CL_HIGH) ? pv1 : pv0}} & ~dm_q;
    end
  end

  // Register bus: one wait cycle, then the answer
  // Power down when idle, suspend when a burst is held
  assign pd_now = ~cke_q & ~bst_act & ~sr_q;
  assign susp_now = ~cke_q & bst_act;
  assign status[31:8] = 24'h000000;
  assign status[`ST_SREF] = sr_q;
  assign status[`ST_PDOWN] = pd_now;
  assign status[`ST_SUSPEND] = susp_now;
  assign status[`ST_AP] = ap_pend;
  // Write flag only while a burst is running
  assign status[`ST_WRITE] = bst_wr & bst_act;
  assign status[`ST_BURST] = bst_act;
  assign status[`ST_BANK_LSB +: 2] = bank_open;

  // Request seen on the first edge, taken on the edge with the stall low
  assign bus_req = avs_read | avs_write;
  assign bus_take = bus_req & ~avs_waitrequest;

  always @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      mode_q <= `MODE_RST;
    end
    else
    begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read & avs_waitrequest)
      begin
        if (avs_address == `REG_MODE)
          avs_readdata <= {27'h0000000, mode_q};
        else if (avs_address == `REG_STATUS)
          avs_readdata <= status;
        else
          avs_readdata <= 32'h00000000;
      end
      if (bus_take & avs_write & (avs_address == `REG_MODE) & avs_byteenable[0])
        mode_q <= avs_writedata[4:0];
    end
  end

endmodule // sdram_burst_command_logic
`default_nettype wire

/* testbench/mem_ctrl_model.sv */
// Controller model driving the memory command and data pins
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
  input wire logic ref_clk, // System clock
  output logic [3:0] cmd, // Select, row, column, write strobes
  output logic clock_gate, // Clock enable
  output logic array_pick, // Bank select
  output logic [10:0] addr_pins, // Address
  output logic [1:0] byte_mask, // Data mask
  output logic [15:0] dq_in // Write data
);
  initial
  begin
    cmd = 4'hf;
    clock_gate = 1'b1;
    array_pick = 1'b0;
    addr_pins = 11'h0;
    byte_mask = 2'h0;
    dq_in = 16'h0;
  end
  // One command per clock; released data toggles every cycle
  task automatic issue(input logic [3:0] c, input logic b, input logic [10:0] a, input logic [15:0] d,
    input logic w, input logic g);
  begin
    cmd <= c;
    array_pick <= b;
    addr_pins <= a;
    clock_gate <= g;
    dq_in <= w ? d : ~dq_in;
    @(posedge ref_clk);
  end
  endtask
  // Mask changes with the next command
  task automatic set_mask(input logic [1:0] v);
    byte_mask <= v;
  endtask
endmodule // mem_ctrl_model
`default_nettype wire

/* testbench/sdram_burst_props.sv */
// Port checker for the DRAM burst command logic
`timescale 1ns/1ps
`default_nettype none
module sdram_burst_props (
  input wire logic ref_clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic chip_select_n, // Select
  input wire logic row_strobe_n, // Row strobe
  input wire logic column_strobe_n, // Column strobe
  input wire logic write_strobe_n, // Write strobe
  input wire logic clock_gate, // Clock enable
  input wire logic [1:0] byte_mask, // Data mask
  input wire logic [15:0] dq_out, // Read data
  input wire logic [1:0] dq_oe, // Drive enable
  input wire logic [3:0] avs_address, // Bus address
  input wire logic avs_read, // Bus read
  input wire logic avs_write, // Bus write
  input wire logic [31:0] avs_readdata, // Bus read data
  input wire logic avs_waitrequest // Bus stall
);
  logic cg_q;
  always @(posedge ref_clk)
    cg_q <= clock_gate;
  wire rd_cmd = !chip_select_n && row_strobe_n && !column_strobe_n && write_strobe_n && cg_q;
  wire sr_cmd = !chip_select_n && !row_strobe_n && !column_strobe_n && write_strobe_n && !clock_gate && cg_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_halt;
    !clock_gate ##1 !clock_gate;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> dq_oe == 2'h0 && avs_waitrequest)
    else $error("outputs active after reset");
  a_req_answer: assert property (s_req |-> ##[1:2] !avs_waitrequest)
    else $error("bus request not answered");
  a_ack_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer longer than one cycle");
  a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address != 4'h0 && avs_address != 4'h4
    |-> ##2 avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_rdata_stands: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_suspend_hold: assert property (s_halt |=> $stable(dq_out) && $stable(dq_oe))
    else $error("outputs moved while clock held");
  a_read_launch: assert property ($rose(dq_oe[0]) && !$past(byte_mask[0], 3)
    |-> $past(rd_cmd, 2) || $past(rd_cmd, 3)) else $error("drive began without a read at latency");
  a_sref_quiet: assert property (sr_cmd |=> (dq_oe == 2'h0) [*3])
    else $error("drive during self refresh");
endmodule // sdram_burst_props
bind sdram_burst_command_logic sdram_burst_props u_props (.ref_clk, .rst_b, .chip_select_n, .row_strobe_n,
  .column_strobe_n, .write_strobe_n, .clock_gate, .byte_mask, .dq_out, .dq_oe, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest);
`default_nettype wire

/* testbench/sdram_burst_command_logic_tb.sv */
// Self-checking bench for the DRAM burst command logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; $display("mismatch at %0t: %h not %h", $time, (a), (e)); end end
module sdram_burst_command_logic_tb;
  localparam logic [3:0] NOP = 4'h7, DES = 4'hf, ACT = 4'h3, RD = 4'h5, WR = 4'h4, BST = 4'h6, PRE = 4'h2, SRF = 4'h1;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cg = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] q;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, clock_gate, array_pick;
  wire [3:0] cmd;
  wire [10:0] addr_pins;
  wire [1:0] byte_mask, dq_oe;
  wire [15:0] dq_in, dq_out;
  int mismatches = 0;
  int comparisons = 0;
  always #12.5 ref_clk = ~ref_clk;
  mem_ctrl_model u_ctrl (.ref_clk, .cmd, .clock_gate, .array_pick, .addr_pins, .byte_mask, .dq_in);
  sdram_burst_command_logic #(.COL_STORE_W(4)) u_dut (.ref_clk, .rst_b, .chip_select_n(cmd[3]),
    .row_strobe_n(cmd[2]), .column_strobe_n(cmd[1]), .write_strobe_n(cmd[0]), .clock_gate, .array_pick,
    .addr_pins, .byte_mask, .dq_in, .dq_out, .dq_oe, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest);
  task automatic results;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
  begin
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge ref_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  end
  endtask
  task automatic m(input logic [3:0] c, input logic [11:0] a, input logic [16:0] d);
    u_ctrl.issue(c, a[11], a[10:0], d[15:0], d[16], cg);
  endtask
  // Read burst of eight beats; expected word is base plus column
  task automatic burst(input logic [7:0] col, input int cl, input logic il, input logic [15:0] base);
    logic [7:0] c;
  begin
    m(RD, {4'h0, col}, 17'h0);
    repeat (cl - 1)
      m(DES, 12'h0, 17'h0);
    for (int i = 0; i < 8; i++)
    begin
      c = il ? col ^ i[7:0] : {col[7:3], col[2:0] + i[2:0]};
      #1;
      `CHK(dq_out, base + c)
      `CHK(dq_oe, 2'h3)
      m(DES, 12'h0, 17'h0);
    end
  end
  endtask
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    bus(0, 4'h4, 32'h0, 4'hf);
    `CHK(q, 32'h0)
    bus(1, 4'h8, 32'hff, 4'hf);
    bus(0, 4'h8, 32'h0, 4'hf);
    `CHK(q, 32'h0)
    bus(1, 4'h0, 32'h17, 4'h0);
    bus(0, 4'h0, 32'h0, 4'hf);
    `CHK(q, 32'h13)
    bus(1, 4'h0, 32'h17, 4'hf);
    $display("test registers done");
    m(ACT, 12'h0, 17'h0);
    m(NOP, 12'h0, 17'h0);
    for (int i = 0; i < 16; i++)
      m(i == 0 ? WR : NOP, 12'h0, {1'b1, 16'ha500 + i[15:0]});
    m(BST, 12'h0, 17'h1dead);
    m(NOP, 12'h0, 17'h0);
    bus(1, 4'h0, 32'h13, 4'hf);
    burst(8'h5, 3, 1'b0, 16'ha500);
    bus(1, 4'h0, 32'h0b, 4'hf);
    burst(8'h5, 2, 1'b1, 16'ha500);
    bus(1, 4'h0, 32'h13, 4'hf);
    m(RD, 12'h0, 17'h0);
    burst(8'h4, 3, 1'b0, 16'ha500);
    for (int i = 0; i < 9; i++)
      m(i == 0 ? WR : NOP, 12'h8, {1'b1, i == 8 ? 16'hdead : 16'hb000 + i[15:0]});
    burst(8'h8, 3, 1'b0, 16'haff8);
    u_ctrl.set_mask(2'h1);
    m(RD, 12'h0, 17'h0);
    m(DES, 12'h0, 17'h0);
    m(DES, 12'h0, 17'h0);
    #1;
    `CHK(dq_oe, 2'h2)
    u_ctrl.set_mask(2'h0);
    m(DES, 12'h0, 17'h0);
    m(DES, 12'h0, 17'h0);
    #1;
    `CHK(dq_oe, 2'h3)
    repeat (6)
      m(DES, 12'h0, 17'h0);
    $display("test bursts done");
    cg = 1'b0;
    m(NOP, 12'h0, 17'h0);
    m(NOP, 12'h0, 17'h0);
    bus(0, 4'h4, 32'h0, 4'hf);
    `CHK(q, 32'h41)
    cg = 1'b1;
    m(NOP, 12'h0, 17'h0);
    m(PRE, 12'h400, 17'h0);
    m(NOP, 12'h0, 17'h0);
    bus(0, 4'h4, 32'h0, 4'hf);
    `CHK(q, 32'h0)
    cg = 1'b0;
    m(SRF, 12'h0, 17'h0);
    m(RD, 12'h0, 17'h0);
    bus(0, 4'h4, 32'h0, 4'hf);
    `CHK(q, 32'h80)
    cg = 1'b1;
    m(NOP, 12'h0, 17'h0);
    m(NOP, 12'h0, 17'h0);
    bus(0, 4'h4, 32'h0, 4'hf);
    `CHK(q, 32'h0)
    $display("test power modes done");
    m(ACT, 12'h800, 17'h0);
    m(NOP, 12'h0, 17'h0);
    for (int i = 0; i < 8; i++)
      m(i == 0 ? WR : NOP, 12'hc00, {1'b1, 16'hc000 + i[15:0]});
    m(NOP, 12'h0, 17'h0);
    m(NOP, 12'h0, 17'h0);
    bus(0, 4'h4, 32'h0, 4'hf);
    `CHK(q, 32'h0)
    $display("test auto precharge done");
    results();
  end
  initial
  begin
    #100000;
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end
endmodule // sdram_burst_command_logic_tb
`default_nettype wire
